// ===== rtl/mlx_mode_latch_ext_irq.sv
// Operation
// RQ1: Latch both mode pins at reset release
// RQ2: First mode pin becomes request A after reset
// RQ3: Second mode pin becomes request B after reset
// RQ4: Software may rewrite mode after reset
// RQ5: Request A passes a synchroniser first
// RQ6: Request A level-low or falling-edge selectable
// RQ7: Request A asserted wakes processor from stop
// RQ8: Request B synchronised before use
// RQ9: Request B level-low or falling-edge selectable
// RQ10: Reset low initialises and holds reset state
// RQ11: Internal reset released synchronously to clock
// RQ12: Detected falling edge held until cleared
module mlx_mode_latch_ext_irq
  import mlx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire mlx_cfg_wr_t cfg_wr,
  input wire logic clr_a,
  input wire logic clr_b,
  input wire logic in_stop,
  output logic [1:0] op_mode,
  output logic int_rst_n,
  output mlx_irq_t irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser: asserts at once, releases on a clock edge
  logic [MLX_RST_SYNC_W-1:0] rst_sync_r;
  logic [MLX_RST_SYNC_W-1:0] rst_sync_nxt;

  // Ones shift in behind release; only the top bit is read, never the first
  always_comb
  begin
    rst_sync_nxt = {rst_sync_r[MLX_RST_SYNC_W-2:0], 1'b1}; // see RQ11
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= '0; // see RQ10
    else
      rst_sync_r <= rst_sync_nxt;
  end

  logic rst_done;
  assign rst_done = rst_sync_r[MLX_RST_SYNC_W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  logic a_s1_r;
  logic a_s2_r;
  logic b_s1_r;
  logic b_s2_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      a_s1_r <= 1'b1;
      a_s2_r <= 1'b1;
      b_s1_r <= 1'b1;
      b_s2_r <= 1'b1;
    end
    else
    begin
      a_s1_r <= mode_select_a; // see RQ5
      a_s2_r <= a_s1_r;
      b_s1_r <= mode_select_b; // see RQ8
      b_s2_r <= b_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, mode and trigger configuration
  mlx_state_t state_r;
  mlx_state_t state_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic trig_a_r;
  logic trig_a_nxt;
  logic trig_b_r;
  logic trig_b_nxt;
  logic int_rst_n_r;
  logic int_rst_n_nxt;

  // Latch happens on the fourth clock edge after release, so synchronised pins hold
  // the pre-release strap level rather than any later interrupt traffic
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    trig_a_nxt = trig_a_r;
    trig_b_nxt = trig_b_r;
    int_rst_n_nxt = int_rst_n_r;
    case (state_r)
      MLX_ST_RESET:
      begin
        if (rst_done)
          state_nxt = MLX_ST_LATCH;
      end
      MLX_ST_LATCH:
      begin
        mode_nxt = {b_s2_r, a_s2_r}; // see RQ1
        int_rst_n_nxt = 1'b1; // see RQ11
        state_nxt = MLX_ST_RUN;
      end
      MLX_ST_RUN:
      begin
        if (cfg_wr.mode_we)
          mode_nxt = cfg_wr.mode_wdata; // see RQ4
        if (cfg_wr.cfg_we)
        begin
          trig_a_nxt = cfg_wr.trig_a; // see RQ6
          trig_b_nxt = cfg_wr.trig_b; // see RQ9
        end
      end
      default:
        state_nxt = MLX_ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= MLX_ST_RESET; // see RQ10
      mode_r <= MLX_MODE_RST;
      trig_a_r <= MLX_TRIG_LEVEL;
      trig_b_r <= MLX_TRIG_LEVEL;
      int_rst_n_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      trig_a_r <= trig_a_nxt;
      trig_b_r <= trig_b_nxt;
      int_rst_n_r <= int_rst_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request logic, live only once running
  logic run;
  logic a_prev_r;
  logic a_prev_nxt;
  logic b_prev_r;
  logic b_prev_nxt;
  logic pend_a_r;
  logic pend_a_nxt;
  logic pend_b_r;
  logic pend_b_nxt;
  logic wake_r;
  logic wake_nxt;
  logic fall_a;
  logic fall_b;
  logic req_a;

  assign run = (state_r == MLX_ST_RUN);

  // Edge memory set wins over a clear in the same cycle
  always_comb
  begin
    a_prev_nxt = a_s2_r;
    b_prev_nxt = b_s2_r;
    fall_a = run && a_prev_r && !a_s2_r;
    fall_b = run && b_prev_r && !b_s2_r;
    pend_a_nxt = pend_a_r;
    pend_b_nxt = pend_b_r;
    if (!run)
    begin
      pend_a_nxt = 1'b0;
      pend_b_nxt = 1'b0;
    end
    else
    begin
      if (trig_a_r == MLX_TRIG_FALL) // see RQ2
      begin
        if (fall_a)
          pend_a_nxt = 1'b1; // see RQ12
        else if (clr_a)
          pend_a_nxt = 1'b0;
      end
      else
        pend_a_nxt = !a_s2_r; // see RQ6
      if (trig_b_r == MLX_TRIG_FALL) // see RQ3
      begin
        if (fall_b)
          pend_b_nxt = 1'b1; // see RQ12
        else if (clr_b)
          pend_b_nxt = 1'b0;
      end
      else
        pend_b_nxt = !b_s2_r; // see RQ9
    end
    req_a = (trig_a_r == MLX_TRIG_FALL) ? (fall_a || pend_a_r) : !a_s2_r;
    wake_nxt = run && in_stop && req_a; // see RQ7
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      a_prev_r <= 1'b1;
      b_prev_r <= 1'b1;
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      a_prev_r <= a_prev_nxt;
      b_prev_r <= b_prev_nxt;
      pend_a_r <= pend_a_nxt;
      pend_b_r <= pend_b_nxt;
      wake_r <= wake_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign op_mode = mode_r;
  assign int_rst_n = int_rst_n_r;
  assign irq = '{pend_a: pend_a_r, pend_b: pend_b_r, wake: wake_r};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_latch;
    state_r == MLX_ST_LATCH;
  endsequence

  property p_mode_latch;
    @(posedge sys_clk) disable iff (!nrst)
    s_latch |=> (op_mode == $past({b_s2_r, a_s2_r}));
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched"); // see RQ1

  property p_rel_sync;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(int_rst_n) |-> $past(state_r) == MLX_ST_LATCH && $past(rst_done, 2);
  endproperty
  a_rel_sync: assert property (p_rel_sync) else $error("reset release unsynced"); // see RQ11

  property p_rst_hold;
    @(posedge sys_clk) !nrst |-> !int_rst_n && !irq.pend_a && !irq.pend_b;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not held"); // see RQ10

  property p_mode_wr;
    @(posedge sys_clk) disable iff (!nrst)
    run && cfg_wr.mode_we |=> op_mode == $past(cfg_wr.mode_wdata);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost"); // see RQ4

  property p_sync_a;
    @(posedge sys_clk) disable iff (!nrst)
    run && trig_a_r == MLX_TRIG_LEVEL && $past(run) ##0 !$past(mode_select_a, 3)
      && !$past(mode_select_a, 2) |=> irq.pend_a;
  endproperty
  a_sync_a: assert property (p_sync_a) else $error("request a level lost"); // see RQ5

  property p_edge_hold_a;
    @(posedge sys_clk) disable iff (!nrst)
    run && trig_a_r == MLX_TRIG_FALL && irq.pend_a && !clr_a |=> irq.pend_a || !run;
  endproperty
  a_edge_hold_a: assert property (p_edge_hold_a) else $error("pending a dropped"); // see RQ12

  property p_edge_hold_b;
    @(posedge sys_clk) disable iff (!nrst)
    run && trig_b_r == MLX_TRIG_FALL && irq.pend_b && !clr_b |=> irq.pend_b || !run;
  endproperty
  a_edge_hold_b: assert property (p_edge_hold_b) else $error("pending b dropped"); // see RQ12

  property p_edge_a;
    @(posedge sys_clk) disable iff (!nrst)
    fall_a && trig_a_r == MLX_TRIG_FALL |=> irq.pend_a;
  endproperty
  a_edge_a: assert property (p_edge_a) else $error("edge a missed"); // see RQ6

  // Level view of B lags the pin by the two synchroniser stages plus the pending flop
  property p_sync_b;
    @(posedge sys_clk) disable iff (!nrst)
    run && trig_b_r == MLX_TRIG_LEVEL && !$past(mode_select_b, 2) |=> irq.pend_b;
  endproperty
  a_sync_b: assert property (p_sync_b) else $error("request b level lost"); // see RQ8

  property p_level_b;
    @(posedge sys_clk) disable iff (!nrst)
    run && trig_b_r == MLX_TRIG_LEVEL |=> irq.pend_b == !$past(b_s2_r) || !run;
  endproperty
  a_level_b: assert property (p_level_b) else $error("request b level wrong"); // see RQ9

  property p_edge_b;
    @(posedge sys_clk) disable iff (!nrst)
    fall_b && trig_b_r == MLX_TRIG_FALL |=> irq.pend_b;
  endproperty
  a_edge_b: assert property (p_edge_b) else $error("edge b missed"); // see RQ9

  property p_wake;
    @(posedge sys_clk) disable iff (!nrst)
    run && in_stop && trig_a_r == MLX_TRIG_LEVEL && !a_s2_r |=> irq.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no stop wake"); // see RQ7

  property p_wake_quiet;
    @(posedge sys_clk) disable iff (!nrst)
    !in_stop |=> !irq.wake;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake outside stop"); // see RQ7

endmodule : mlx_mode_latch_ext_irq

// ===== rtl/mlx_pkg.sv
package mlx_pkg;

  // Operating mode pair, bit 1 from the second pin, bit 0 from the first
  localparam int MLX_MODE_W = 2;
  localparam logic [1:0] MLX_MODE_RST = 2'h0;

  // Edge/level selection encoding
  localparam logic MLX_TRIG_LEVEL = 1'b0;
  localparam logic MLX_TRIG_FALL = 1'b1;

  // Depth of the reset release synchroniser
  localparam int MLX_RST_SYNC_W = 2;

  // Reset sequencing states
  typedef enum logic [2:0] {
    MLX_ST_RESET = 3'b001,
    MLX_ST_LATCH = 3'b010,
    MLX_ST_RUN = 3'b100
  } mlx_state_t;

  // Software write port for the mode and trigger configuration
  typedef struct packed {
    logic mode_we;
    logic [1:0] mode_wdata;
    logic cfg_we;
    logic trig_a;
    logic trig_b;
  } mlx_cfg_wr_t;

  // Interrupt side outputs
  typedef struct packed {
    logic pend_a;
    logic pend_b;
    logic wake;
  } mlx_irq_t;

endpackage : mlx_pkg

// ===== tb/mlx_ext_dev.sv
// Far-side device on the two shared pins
module mlx_ext_dev
(
  input wire logic straps_on,
  input wire logic [1:0] strap,
  input wire logic [1:0] req,
  output logic mode_select_a,
  output logic mode_select_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strap levels in reset, then active-low requests; idle is the pull-up high
  assign mode_select_a = straps_on ? strap[0] : ~req[0];
  assign mode_select_b = straps_on ? strap[1] : ~req[1];
endmodule : mlx_ext_dev

// ===== tb/mlx_mode_latch_ext_irq_test.sv
module mlx_mode_latch_ext_irq_test
  import mlx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic nrst = 1'b1;
  logic straps_on = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [1:0] req = 2'h0;
  logic [1:0] clr = 2'h0;
  logic in_stop = 1'b0;
  mlx_cfg_wr_t cfg = '0;
  logic mode_select_a;
  logic mode_select_b;
  logic [1:0] op_mode;
  logic int_rst_n;
  mlx_irq_t irq;
  wire [1:0] pend = {irq.pend_b, irq.pend_a};
  int miscompares = 0;
  int check_count = 0;

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  mlx_ext_dev dev (.straps_on(straps_on), .strap(strap), .req(req),
    .mode_select_a(mode_select_a), .mode_select_b(mode_select_b));

  mlx_mode_latch_ext_irq dut (.sys_clk(sys_clk), .nrst(nrst),
    .mode_select_a(mode_select_a), .mode_select_b(mode_select_b), .cfg_wr(cfg),
    .clr_a(clr[0]), .clr_b(clr[1]), .in_stop(in_stop), .op_mode(op_mode),
    .int_rst_n(int_rst_n), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // Reset with a given strap pair; straps held well past the latch edge
  task automatic do_reset(input logic [1:0] s);
    int i;
    @(posedge sys_clk);
    strap <= s;
    straps_on <= 1'b1;
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({op_mode, int_rst_n}, 3'h0);
    chk(irq, 3'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk({2'h0, int_rst_n}, 3'h0);
    i = 0;
    while (int_rst_n !== 1'b1 && i < 20)
    begin
      @(negedge sys_clk);
      i++;
    end
    // A hang here ends the run rather than cascading
    if (i == 20)
    begin
      miscompares++;
      test_done;
    end
    chk({1'b0, op_mode}, {1'b0, s});
    repeat (3) @(posedge sys_clk);
    straps_on <= 1'b0;
  endtask : do_reset

  // Software rewrite of the latched mode
  task automatic mode_write;
    @(posedge sys_clk);
    cfg <= '{1'h1, 2'h3, 1'h0, 1'h0, 1'h0};
    @(posedge sys_clk);
    cfg <= '0;
    @(negedge sys_clk);
    chk({1'b0, op_mode}, 3'h3);
  endtask : mode_write

  // Level mode: pending only after the synchroniser, drops with the pin
  task automatic lvl(input int ch);
    logic [1:0] m;
    m = 2'h1 << ch;
    @(posedge sys_clk);
    req <= m;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({1'b0, pend}, 3'h0);
    @(negedge sys_clk);
    chk({1'b0, pend}, {1'b0, m});
    @(posedge sys_clk);
    req <= 2'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({1'b0, pend}, 3'h0);
  endtask : lvl

  // Stop exit only when request A arrives
  task automatic wake_test;
    @(posedge sys_clk);
    in_stop <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({2'h0, irq.wake}, 3'h0);
    @(posedge sys_clk);
    req <= 2'h1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({2'h0, irq.wake}, 3'h1);
    @(posedge sys_clk);
    req <= 2'h0;
    in_stop <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask : wake_test

  // Edge mode: a short pulse stays pending until cleared
  task automatic edg(input int ch);
    logic [1:0] m;
    m = 2'h1 << ch;
    @(posedge sys_clk);
    cfg <= '{1'h0, 2'h0, 1'h1, 1'h1, 1'h1};
    req <= m;
    repeat (2) @(posedge sys_clk);
    cfg <= '0;
    req <= 2'h0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({1'b0, pend}, {1'b0, m});
    @(posedge sys_clk);
    clr <= m;
    @(posedge sys_clk);
    clr <= 2'h0;
    @(negedge sys_clk);
    chk({1'b0, pend}, 3'h0);
  endtask : edg

  // Reset in mid-run with edges pending; triggers must fall back to level
  task automatic mid_reset;
    @(posedge sys_clk);
    cfg <= '{1'h0, 2'h0, 1'h1, 1'h1, 1'h1};
    req <= 2'h3;
    @(posedge sys_clk);
    cfg <= '0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({1'b0, pend}, 3'h3);
    @(posedge sys_clk);
    req <= 2'h0;
    do_reset(2'h2);
    repeat (3) @(posedge sys_clk);
    lvl(0);
  endtask : mid_reset

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    for (int s = 3; s >= 0; s--)
      do_reset(s[1:0]);
    mode_write();
    lvl(0);
    lvl(1);
    wake_test();
    edg(0);
    edg(1);
    mid_reset();
    test_done();
  end
endmodule : mlx_mode_latch_ext_irq_test
